// ===== hw/cal_top.v
// What this block does
// - software writes and reads back the month counter through its register
// - month: tens bit at bit 4, ones digit bits 3..0, top bits zero
// - software writes and reads back the year counter through its register
// - year: tens digit bits 7..4, ones digit bits 3..0, both bcd
// - minute alarm bit 7 disables the compare when 1, resets to 1
// - a disabled alarm field always passes its term, but with both fields disabled the alarm never matches
// - an enabled minute alarm needs current minute equal to stored minute
// - minute compare: tens bits 6..4, ones bits 3..0, bcd
// - hour alarm bit 7 disables the hour compare when 1, resets to 1
// - an enabled hour alarm needs current hour equal to stored hour
// - hour compare: tens bits 5..4, ones bits 3..0, bcd
// - alarm registers stay plain read/write storage usable as spare bytes
`include "cal_regs.vh"

module cal_top #(
   parameter AW = 8
) (
   input  wire          clk_sys,
   input  wire          nrst,
   // axi4-lite write address
   input  wire [AW-1:0] s_axi_awaddr,
   input  wire [2:0]    s_axi_awprot,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   // axi4-lite write data
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   // axi4-lite write response
   output wire [1:0]    s_axi_bresp,
   output wire          s_axi_bvalid,
   input  wire          s_axi_bready,
   // axi4-lite read address
   input  wire [AW-1:0] s_axi_araddr,
   input  wire [2:0]    s_axi_arprot,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   // axi4-lite read data
   output wire [31:0]   s_axi_rdata,
   output wire [1:0]    s_axi_rresp,
   output wire          s_axi_rvalid,
   input  wire          s_axi_rready,
   // calendar side
   input  wire          month_carry,
   input  wire [6:0]    cur_minute,
   input  wire [5:0]    cur_hour,
   output wire [7:0]    month_value,
   output wire [7:0]    year_value,
   output wire [7:0]    day_alarm_value,
   output wire          alarm_match
);

   // ****************************************************************
   // state
   // ****************************************************************
   reg  [7:0]    month_count_reg;
   reg  [7:0]    month_count_next;
   reg  [7:0]    year_count_reg;
   reg  [7:0]    year_count_next;
   reg  [7:0]    minute_alarm_compare_reg;
   reg  [7:0]    minute_alarm_compare_next;
   reg  [7:0]    hour_alarm_compare_reg;
   reg  [7:0]    hour_alarm_compare_next;
   reg  [7:0]    day_alarm_compare_reg;
   reg  [7:0]    day_alarm_compare_next;
   reg           alarm_match_reg;
   reg           alarm_match_next;

   reg           aw_hold_reg;
   reg           aw_hold_next;
   reg  [AW-1:0] aw_addr_reg;
   reg  [AW-1:0] aw_addr_next;
   reg           w_hold_reg;
   reg           w_hold_next;
   reg  [7:0]    w_data_reg;
   reg  [7:0]    w_data_next;
   reg           w_strb_reg;
   reg           w_strb_next;
   reg           awready_reg;
   reg           awready_next;
   reg           wready_reg;
   reg           wready_next;
   reg           bvalid_reg;
   reg           bvalid_next;
   reg  [1:0]    bresp_reg;
   reg  [1:0]    bresp_next;
   reg           arready_reg;
   reg           arready_next;
   reg           rvalid_reg;
   reg           rvalid_next;
   reg  [31:0]   rdata_reg;
   reg  [31:0]   rdata_next;
   reg  [1:0]    rresp_reg;
   reg  [1:0]    rresp_next;

   wire          do_write;
   wire [AW-3:0] wr_index;
   wire [AW-3:0] rd_index;
   wire          wr_hit;
   reg  [7:0]    rd_byte;
   reg           rd_hit;

   // ****************************************************************
   // outputs straight from flip-flops
   // ****************************************************************
   assign s_axi_awready   = awready_reg;
   assign s_axi_wready    = wready_reg;
   assign s_axi_bvalid    = bvalid_reg;
   assign s_axi_bresp     = bresp_reg;
   assign s_axi_arready   = arready_reg;
   assign s_axi_rvalid    = rvalid_reg;
   assign s_axi_rdata     = rdata_reg;
   assign s_axi_rresp     = rresp_reg;
   assign month_value     = month_count_reg;
   assign year_value      = year_count_reg;
   assign day_alarm_value = day_alarm_compare_reg;
   assign alarm_match     = alarm_match_reg;

   // ****************************************************************
   // calendar carry chain
   // ****************************************************************
   wire [3:0] year_digit [0:1];
   wire [3:0] year_digit_inc [0:1];
   wire [2:0] year_carry;
   wire       month_wrap;
   wire       month_ones_wrap;

   // month 12 rolls to 1 and carries into the year
   assign month_wrap      = month_carry & (month_count_reg == `CAL_MONTH_LAST);
   assign month_ones_wrap = month_count_reg[3:0] == `CAL_BCD_NINE;
   assign year_carry[0]   = month_wrap;
   assign year_digit[0]   = year_count_reg[3:0];
   assign year_digit[1]   = year_count_reg[7:4];

   // year ones then tens, each wrapping 9 to 0
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_year
         cal_bcd_inc #(
            .LAST      (`CAL_BCD_NINE)
         ) u_digit (
            .digit_in  (year_digit[gi]),
            .carry_in  (year_carry[gi]),
            .digit_out (year_digit_inc[gi]),
            .carry_out (year_carry[gi+1])
         );
      end
   endgenerate

   // ****************************************************************
   // alarm compare
   // ****************************************************************
   wire minute_match_disable;
   wire hour_match_disable;
   wire minute_term_ok;
   wire hour_term_ok;

   assign minute_match_disable = minute_alarm_compare_reg[`CAL_ALM_DIS_BIT];
   assign hour_match_disable   = hour_alarm_compare_reg[`CAL_ALM_DIS_BIT];

   // minute term over tens bits 6..4 and ones bits 3..0
   cal_alarm_cmp #(
      .W             (7)
   ) u_min_cmp (
      .match_disable (minute_match_disable),
      .stored        (minute_alarm_compare_reg[`CAL_MIN_CMP_MSB:0]),
      .current       (cur_minute),
      .term_ok       (minute_term_ok)
   );

   // hour term over bits 5..0 only, spare bit left out
   cal_alarm_cmp #(
      .W             (6)
   ) u_hour_cmp (
      .match_disable (hour_match_disable),
      .stored        (hour_alarm_compare_reg[`CAL_HOUR_CMP_MSB:0]),
      .current       (cur_hour),
      .term_ok       (hour_term_ok)
   );

   // match needs every enabled term and at least one enabled
   always @* begin
      alarm_match_next = minute_term_ok & hour_term_ok &
                         ~(minute_match_disable & hour_match_disable);
   end

   // ****************************************************************
   // write channel
   // ****************************************************************
   assign do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
   assign wr_index = aw_addr_reg[AW-1:2];
   assign wr_hit   = (wr_index >= `CAL_IDX_MONTH) & (wr_index <= `CAL_IDX_STATUS);

   // address and data taken in either order, response after both
   always @* begin
      aw_hold_next = aw_hold_reg;
      aw_addr_next = aw_addr_reg;
      w_hold_next  = w_hold_reg;
      w_data_next  = w_data_reg;
      w_strb_next  = w_strb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      if (s_axi_awvalid && awready_reg) begin
         aw_hold_next = 1'b1;
         aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
         w_hold_next = 1'b1;
         w_data_next = s_axi_wdata[7:0];
         w_strb_next = s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_hold_next = 1'b0;
         w_hold_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = wr_hit ? `CAL_RESP_OKAY : `CAL_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      awready_next = ~aw_hold_next & ~bvalid_next;
      wready_next  = ~w_hold_next & ~bvalid_next;
   end

   // ****************************************************************
   // register updates
   // ****************************************************************
   always @* begin
      month_count_next          = month_count_reg;
      year_count_next           = year_count_reg;
      minute_alarm_compare_next = minute_alarm_compare_reg;
      hour_alarm_compare_next   = hour_alarm_compare_reg;
      day_alarm_compare_next    = day_alarm_compare_reg;
      // calendar advance from the day counter
      if (month_carry) begin
         if (month_wrap) begin
            month_count_next = `CAL_MONTH_RST;
         end else if (month_ones_wrap) begin
            month_count_next = 8'h10;
         end else begin
            month_count_next = {3'h0, month_count_reg[4], month_count_reg[3:0] + 4'h1};
         end
      end
      year_count_next = {year_digit_inc[1], year_digit_inc[0]};
      // a software write overrides the advance in the same cycle
      if (do_write && w_strb_reg) begin
         case (wr_index)
            `CAL_IDX_MONTH: begin
               month_count_next = w_data_reg & `CAL_MONTH_MASK;
            end
            `CAL_IDX_YEAR: begin
               year_count_next = w_data_reg;
            end
            `CAL_IDX_MIN_ALM: begin
               minute_alarm_compare_next = w_data_reg;
            end
            `CAL_IDX_HOUR_ALM: begin
               hour_alarm_compare_next = w_data_reg;
            end
            `CAL_IDX_DAY_ALM: begin
               day_alarm_compare_next = w_data_reg;
            end
            default: begin
               day_alarm_compare_next = day_alarm_compare_reg;
            end
         endcase
      end
   end

   // ****************************************************************
   // read channel
   // ****************************************************************
   assign rd_index = s_axi_araddr[AW-1:2];

   // read mux, unmapped reads return zero with an error
   always @* begin
      rd_byte = 8'h00;
      rd_hit  = 1'b1;
      case (rd_index)
         `CAL_IDX_MONTH:    rd_byte = month_count_reg & `CAL_MONTH_MASK;
         `CAL_IDX_YEAR:     rd_byte = year_count_reg;
         `CAL_IDX_MIN_ALM:  rd_byte = minute_alarm_compare_reg;
         `CAL_IDX_HOUR_ALM: rd_byte = hour_alarm_compare_reg;
         `CAL_IDX_DAY_ALM:  rd_byte = day_alarm_compare_reg;
         `CAL_IDX_STATUS:   rd_byte = {7'h00, alarm_match_reg};
         default:           rd_hit  = 1'b0;
      endcase
   end

   // one read at a time, data one cycle after the address
   always @* begin
      rvalid_next = rvalid_reg;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      if (s_axi_arvalid && arready_reg) begin
         rvalid_next = 1'b1;
         rdata_next  = {24'h000000, rd_byte};
         rresp_next  = rd_hit ? `CAL_RESP_OKAY : `CAL_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
      arready_next = ~rvalid_next;
   end

   // ****************************************************************
   // flip-flops
   // ****************************************************************
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         month_count_reg          <= `CAL_MONTH_RST;
         year_count_reg           <= `CAL_YEAR_RST;
         minute_alarm_compare_reg <= `CAL_ALM_RST;
         hour_alarm_compare_reg   <= `CAL_ALM_RST;
         day_alarm_compare_reg    <= `CAL_ALM_RST;
         alarm_match_reg          <= 1'b0;
         aw_hold_reg              <= 1'b0;
         aw_addr_reg              <= {AW{1'b0}};
         w_hold_reg               <= 1'b0;
         w_data_reg               <= 8'h00;
         w_strb_reg               <= 1'b0;
         awready_reg              <= 1'b0;
         wready_reg               <= 1'b0;
         bvalid_reg               <= 1'b0;
         bresp_reg                <= `CAL_RESP_OKAY;
         arready_reg              <= 1'b0;
         rvalid_reg               <= 1'b0;
         rdata_reg                <= 32'h00000000;
         rresp_reg                <= `CAL_RESP_OKAY;
      end else begin
         month_count_reg          <= month_count_next;
         year_count_reg           <= year_count_next;
         minute_alarm_compare_reg <= minute_alarm_compare_next;
         hour_alarm_compare_reg   <= hour_alarm_compare_next;
         day_alarm_compare_reg    <= day_alarm_compare_next;
         alarm_match_reg          <= alarm_match_next;
         aw_hold_reg              <= aw_hold_next;
         aw_addr_reg              <= aw_addr_next;
         w_hold_reg               <= w_hold_next;
         w_data_reg               <= w_data_next;
         w_strb_reg               <= w_strb_next;
         awready_reg              <= awready_next;
         wready_reg               <= wready_next;
         bvalid_reg               <= bvalid_next;
         bresp_reg                <= bresp_next;
         arready_reg              <= arready_next;
         rvalid_reg               <= rvalid_next;
         rdata_reg                <= rdata_next;
         rresp_reg                <= rresp_next;
      end
   end

endmodule

// ===== hw/cal_regs.vh
`ifndef CAL_REGS_VH
`define CAL_REGS_VH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define CAL_IDX_MONTH        4'h5
`define CAL_IDX_YEAR         4'h6
`define CAL_IDX_MIN_ALM      4'h7
`define CAL_IDX_HOUR_ALM     4'h8
`define CAL_IDX_DAY_ALM      4'h9
`define CAL_IDX_STATUS       4'hA

// ****************************************************************
// field positions
// ****************************************************************
`define CAL_MONTH_TENS_BIT   4
`define CAL_ALM_DIS_BIT      7
`define CAL_HOUR_SPARE_BIT   6
`define CAL_MIN_CMP_MSB      6
`define CAL_HOUR_CMP_MSB     5
`define CAL_STAT_MATCH_BIT   0

// ****************************************************************
// reset values and write masks
// ****************************************************************
`define CAL_MONTH_RST        8'h01
`define CAL_YEAR_RST         8'h00
`define CAL_ALM_RST          8'h80
`define CAL_MONTH_MASK       8'h1F
`define CAL_MONTH_LAST       8'h12
`define CAL_BCD_NINE         4'h9

// ****************************************************************
// bus responses
// ****************************************************************
`define CAL_RESP_OKAY        2'h0
`define CAL_RESP_SLVERR      2'h2

`endif

// ===== hw/cal_bcd_inc.v
// ****************************************************************
// one bcd digit with carry in and carry out
// ****************************************************************
module cal_bcd_inc #(
   parameter [3:0] LAST = 4'h9
) (
   input  wire [3:0] digit_in,
   input  wire       carry_in,
   output wire [3:0] digit_out,
   output wire       carry_out
);

   // wrap to zero after the last value
   assign carry_out = carry_in & (digit_in == LAST);
   assign digit_out = !carry_in ? digit_in :
                      carry_out ? 4'h0 : digit_in + 4'h1;

endmodule

// ===== hw/cal_alarm_cmp.v
// ****************************************************************
// one alarm term: passes when disabled or when equal
// ****************************************************************
module cal_alarm_cmp #(
   parameter W = 7
) (
   input  wire         match_disable,
   input  wire [W-1:0] stored,
   input  wire [W-1:0] current,
   output wire         term_ok
);

   // a disabled term never blocks the alarm
   assign term_ok = match_disable | (stored == current);

endmodule

// ===== verification/cal_top_checker.sv
module cal_chk #(
   parameter AW = 8
) (
   input logic          clk_sys,
   input logic          nrst,
   input logic [AW-1:0] s_axi_awaddr,
   input logic          s_axi_awvalid,
   input logic          s_axi_awready,
   input logic [31:0]   s_axi_wdata,
   input logic          s_axi_wvalid,
   input logic          s_axi_wready,
   input logic          s_axi_bvalid,
   input logic          s_axi_arvalid,
   input logic          s_axi_arready,
   input logic          s_axi_rvalid,
   input logic          s_axi_rready,
   input logic [31:0]   s_axi_rdata,
   input logic          month_carry,
   input logic [6:0]    cur_minute,
   input logic [5:0]    cur_hour,
   input logic [7:0]    month_value,
   input logic [7:0]    year_value,
   input logic          alarm_match
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic [5:0] idx_reg;
   logic [7:0] dat_reg;
   logic [7:0] min_reg;
   logic [7:0] hr_reg;
   logic       aw_reg;
   logic       w_reg;
   wire        hit;
   // ****************
   // alarm byte shadow
   // ****************
   // each write half is held until both are in, as the slave does
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         aw_reg  <= 1'b0;
         w_reg   <= 1'b0;
         idx_reg <= 6'h00;
         dat_reg <= 8'h00;
         min_reg <= 8'h80;
         hr_reg  <= 8'h80;
      end else if (aw_reg && w_reg) begin
         aw_reg <= 1'b0;
         w_reg  <= 1'b0;
         if (idx_reg == 6'h07) min_reg <= dat_reg;
         if (idx_reg == 6'h08) hr_reg <= dat_reg;
      end else begin
         if (s_axi_awvalid && s_axi_awready) aw_reg <= 1'b1;
         if (s_axi_awvalid && s_axi_awready) idx_reg <= s_axi_awaddr[7:2];
         if (s_axi_wvalid && s_axi_wready) w_reg <= 1'b1;
         if (s_axi_wvalid && s_axi_wready) dat_reg <= s_axi_wdata[7:0];
      end
   end
   // expected match: an enabled term must be equal, a disabled one passes
   assign hit = (!min_reg[7] || !hr_reg[7]) && (min_reg[7] || cur_minute == min_reg[6:0])
                && (hr_reg[7] || cur_hour == hr_reg[5:0]);
   // ****************
   // properties
   // ****************
   sequence s_wr_taken;
      aw_reg && w_reg;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (s_wr_taken |=> s_axi_bvalid && !s_axi_awready)
      else $error("write response late");
   a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response late");
   a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_month_top: assert property (month_value[7:5] == 3'h0)
      else $error("month upper bits set");
   a_month_wrap: assert property (month_carry && month_value == 8'h12 && !aw_reg |=> month_value == 8'h01)
      else $error("month did not wrap");
   a_month_ones: assert property (month_carry && month_value == 8'h09 && !aw_reg |=> month_value == 8'h10)
      else $error("month ones carry wrong");
   a_year_wrap: assert property (month_carry && month_value == 8'h12 && year_value == 8'h99 && !aw_reg
      |=> year_value == 8'h00)
      else $error("year did not wrap");
   a_cal_hold: assert property (!month_carry && !(aw_reg && w_reg) |=> $stable(month_value) && $stable(year_value))
      else $error("calendar moved without cause");
   a_alarm_term: assert property (1'b1 |=> alarm_match == $past(hit))
      else $error("alarm match wrong");
endmodule

bind cal_top cal_chk #(.AW(AW)) u_chk (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .month_carry, .cur_minute, .cur_hour, .month_value,
   .year_value, .alarm_match);

// ===== verification/calendar_alarm_registers_test.sv
module calendar_alarm_registers_test;
   timeunit 1ns;
   timeprecision 1ps;
`include "cal_regs.vh"
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        month_carry = 1'b0;
   logic [6:0]  cur_minute = 7'h00;
   logic [5:0]  cur_hour = 6'h00;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, alarm_match;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [7:0]  month_value, year_value, day_alarm_value;
   int          err_count = 0;
   int          comparisons = 0;
   int          k;
   logic [7:0]  q;
   logic [1:0]  r;
   // register rows: index, write data, read back, response
   // alarm bytes reused as storage; index 0xC is unmapped and answers with an error
   logic [31:0] rows [8] = '{32'h05FF1F00, 32'h05121200, 32'h06999900, 32'h07D9D900,
                             32'h087F7F00, 32'h09A5A500, 32'h0A550000, 32'h0C550002};
   // alarm rows: minute byte, hour byte, minute, hour, expected match
   logic [39:0] alms [6] = '{40'h3080301501, 40'h3080311500, 40'h3055301501,
                             40'h3055301600, 40'hB0D6301500, 40'hB155301501};

   cal_top u_dut (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .month_carry, .cur_minute, .cur_hour, .month_value,
      .year_value, .day_alarm_value, .alarm_match);

   // clock at 125 MHz
   always #4 clk_sys = ~clk_sys;

   // ****************
   // helpers
   // ****************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic rst;
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
   endtask
   // write: address and data offered together, each released when taken
   task automatic wr(input logic [5:0] i, input logic [7:0] d, output logic [1:0] rs);
      logic ha, hw, hb;
      int n;
      @(posedge clk_sys);
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      hb = 1'b0;
      for (n = 0; n < 50 && !hb; n++) begin
         @(negedge clk_sys);
         ha = s_axi_awvalid && s_axi_awready;
         hw = s_axi_wvalid && s_axi_wready;
         hb = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge clk_sys);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         if (hb) s_axi_bready <= 1'b0;
      end
      chk(hb, 1'b1, "bvalid");
   endtask
   // read: rready offered with the address, or raised late so the slave has to hold its answer
   task automatic rd(input logic [5:0] i, output logic [7:0] dq, output logic [1:0] rs, input logic late);
      logic ha, hr, rv;
      int n;
      @(posedge clk_sys);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !late;
      hr = 1'b0;
      for (n = 0; n < 50 && !hr; n++) begin
         @(negedge clk_sys);
         ha = s_axi_arvalid && s_axi_arready;
         rv = s_axi_rvalid;
         hr = rv && s_axi_rready;
         dq = s_axi_rdata[7:0];
         rs = s_axi_rresp;
         @(posedge clk_sys);
         if (ha) s_axi_arvalid <= 1'b0;
         s_axi_rready <= (rv || !late) && !hr;
      end
      chk(hr, 1'b1, "rvalid");
   endtask
   task automatic pulse;
      @(posedge clk_sys);
      month_carry <= 1'b1;
      @(posedge clk_sys);
      month_carry <= 1'b0;
      @(negedge clk_sys);
   endtask

   // watchdog: the whole run needs well under 20 us
   initial begin
      #100us;
      err_count++;
      results;
   end

   // ****************
   // tests
   // ****************
   initial begin
      rst;
      for (k = 0; k < 8; k++) begin
         wr(rows[k][29:24], rows[k][23:16], r);
         chk(r, rows[k][1:0], "write response");
         rd(rows[k][29:24], q, r, 1'b0);
         chk(q, rows[k][15:8], "read data");
         chk(r, rows[k][1:0], "read response");
      end
      chk(day_alarm_value, 8'hA5, "day alarm byte");
      $display("register table done");
      wr(`CAL_IDX_MONTH, 8'h12, r);
      wr(`CAL_IDX_YEAR, 8'h99, r);
      pulse;
      chk(month_value, 8'h01, "month wrap");
      chk(year_value, 8'h00, "year wrap");
      wr(`CAL_IDX_MONTH, 8'h09, r);
      pulse;
      chk(month_value, 8'h10, "month ones carry");
      $display("calendar carry done");
      for (k = 0; k < 6; k++) begin
         wr(`CAL_IDX_MIN_ALM, alms[k][39:32], r);
         wr(`CAL_IDX_HOUR_ALM, alms[k][31:24], r);
         cur_minute <= alms[k][22:16];
         cur_hour <= alms[k][13:8];
         repeat (3) @(posedge clk_sys);
         @(negedge clk_sys);
         chk(alarm_match, alms[k][0], "alarm match");
      end
      $display("alarm compare done");
      wr(`CAL_IDX_YEAR, 8'h25, r);
      rst;
      for (k = 5; k < 10; k++) begin
         rd(k[5:0], q, r, 1'b1);
         chk(q, k == 5 ? 8'h01 : k == 6 ? 8'h00 : 8'h80, "reset value");
      end
      chk(alarm_match, 1'b0, "alarm after reset");
      $display("reset values done");
      results;
   end
endmodule
